//--- shared/stl_pkg.sv
// Package for the transmitter lane settings bank: offsets, field layout,
// reset values, bus answers and state codes.
// Assumes a 32-bit AXI4-Lite register bus and one sticky store per lane.
package stl_pkg;

    // Register map
    localparam int          ADDR_W            = 12;
    localparam logic [11:0] LANE_CTRL0_OFFSET = 12'h000;

    // Field positions within the 32-bit register
    localparam int POS_EQ_LO_DEEMPH  = 10;
    localparam int POS_EQ_HI_DEEMPH  = 12;
    localparam int POS_EQ_LOW_SWING  = 14;
    localparam int POS_COARSE_RATE1  = 16;
    localparam int POS_FINE_RATE1    = 18;
    localparam int POS_COARSE_RATE2  = 21;
    localparam int POS_FINE_RATE2    = 23;
    localparam int POS_SLEW_DISABLE  = 26;
    localparam int POS_AMP_BOOST     = 27;
    localparam int POS_RSV_LO        = 29;

    // Stored slice of the register: bits 28:10
    localparam int STORE_BASE = 10;
    localparam int LANE_W     = 19;

    // Field positions within one lane's store
    localparam int S_EQ_LO   = POS_EQ_LO_DEEMPH - STORE_BASE;
    localparam int S_EQ_HI   = POS_EQ_HI_DEEMPH - STORE_BASE;
    localparam int S_EQ_LS   = POS_EQ_LOW_SWING - STORE_BASE;
    localparam int S_CS1     = POS_COARSE_RATE1 - STORE_BASE;
    localparam int S_FS1     = POS_FINE_RATE1 - STORE_BASE;
    localparam int S_CS2     = POS_COARSE_RATE2 - STORE_BASE;
    localparam int S_FS2     = POS_FINE_RATE2 - STORE_BASE;
    localparam int S_SLEW_DIS = POS_SLEW_DISABLE - STORE_BASE;
    localparam int S_BOOST   = POS_AMP_BOOST - STORE_BASE;

    // Values after fundamental reset
    localparam logic [31:0] LANE_CTRL0_RESET = 32'h0802_1400;
    localparam logic [LANE_W-1:0] LANE_RESET =
        LANE_CTRL0_RESET[STORE_BASE +: LANE_W];

    // Coarse edge-rate codes
    localparam logic [1:0] SLEW_48PS = 2'h0;
    localparam logic [1:0] SLEW_50PS = 2'h1;
    localparam logic [1:0] SLEW_60PS = 2'h2;
    localparam logic [1:0] SLEW_89PS = 2'h3;
    localparam logic [1:0] COARSE_FASTEST = SLEW_48PS;
    localparam logic [2:0] FINE_FASTEST   = 3'h0;

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h0,
        RD_RESP = 2'h1
    } stl_rd_e;

endpackage : stl_pkg

//--- tb/stl_tb.sv
// Self-checking bench for the transmitter lane settings bank.
// Assumes the AXI4-Lite slave timing and one-cycle drive lag of the design.
`timescale 1ns/1ps
`default_nettype none

module tb;
    import stl_pkg::*;

    localparam logic [31:0] MASK = 32'h1FFF_FC00;
    localparam logic [7:0]  EQ1  = 8'hB4;

    logic        aclk, aresetn;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, lane_select;
    logic [1:0]  bresp, rresp;
    logic        deemphasis_select, low_swing_enable, rate2_active;
    logic [7:0]  eq_rate1_lanes, tx_eq_ff, tx_coarse_slew_ff, tx_amp_boost_ff;
    logic [11:0] tx_fine_slew_ff;
    logic [31:0] exp_reg [4];
    logic [31:0] rd;
    logic [1:0]  rsp;
    int          err_count, n_checks, c;

    stl_tx_lane_settings dut (
        .aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .lane_select(lane_select),
        .deemphasis_select(deemphasis_select),
        .low_swing_enable(low_swing_enable), .rate2_active(rate2_active),
        .eq_rate1_lanes(eq_rate1_lanes), .tx_eq_ff(tx_eq_ff),
        .tx_coarse_slew_ff(tx_coarse_slew_ff),
        .tx_fine_slew_ff(tx_fine_slew_ff), .tx_amp_boost_ff(tx_amp_boost_ff)
    );

    always #25 aclk = ~aclk;

    task automatic give_verdict;
        $display("Counts: %0d checks, %0d mismatches", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic timed_out;
        err_count++;
        $display("BAD t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
        give_verdict();
    endtask : timed_out

    // Write with address and data offered together, each released when taken
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] r);
        int  i;
        logic aw_t, w_t;
        aw_t = 0;
        w_t  = 0;
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (!aw_t && awready === 1'b1) begin
                aw_t = 1;
                awvalid <= 1'b0;
            end
            if (!w_t && wready === 1'b1) begin
                w_t = 1;
                wvalid <= 1'b0;
            end
            if (bvalid === 1'b1) begin
                break;
            end
        end
        if (i == 50) begin
            timed_out();
        end
        r = bresp;
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        int i;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (arready === 1'b1) begin
                arvalid <= 1'b0;
            end
            if (rvalid === 1'b1) begin
                break;
            end
        end
        if (i == 50) begin
            timed_out();
        end
        d = rdata;
        r = rresp;
    endtask : axi_read

    task automatic wr_lane(input int l, input logic [31:0] d,
                           input logic [3:0] s);
        int b;
        lane_select <= l[3:0];
        axi_write(LANE_CTRL0_OFFSET, d, s, rsp);
        check(32'(rsp), 32'(RESP_OKAY));
        if (l < 4) begin
            for (b = 0; b < 4; b++) begin
                if (s[b]) begin
                    exp_reg[l][8*b +: 8] = d[8*b +: 8];
                end
            end
            exp_reg[l] = exp_reg[l] & MASK;
        end
    endtask : wr_lane

    task automatic rd_all;
        int i;
        for (i = 0; i < 4; i++) begin
            lane_select <= i[3:0];
            axi_read(LANE_CTRL0_OFFSET, rd, rsp);
            check(rd, exp_reg[i]);
            check(32'(rsp), 32'(RESP_OKAY));
        end
    endtask : rd_all

    // Expected drive per lane from the model and the context inputs
    task automatic chk_out;
        int i;
        logic [31:0] v;
        logic [1:0]  e_eq, e_cs;
        logic [2:0]  e_fs;
        repeat (2) @(posedge aclk);
        for (i = 0; i < 4; i++) begin
            v = exp_reg[i];
            e_eq = low_swing_enable ? v[15:14] :
                   !rate2_active ? EQ1[2*i +: 2] :
                   deemphasis_select ? v[11:10] : v[13:12];
            e_cs = v[26] ? COARSE_FASTEST : rate2_active ? v[22:21] : v[17:16];
            e_fs = v[26] ? FINE_FASTEST : rate2_active ? v[25:23] : v[20:18];
            check(32'(tx_eq_ff[2*i +: 2]), 32'(e_eq));
            check(32'(tx_coarse_slew_ff[2*i +: 2]), 32'(e_cs));
            check(32'(tx_fine_slew_ff[3*i +: 3]), 32'(e_fs));
            check(32'(tx_amp_boost_ff[2*i +: 2]), 32'(v[28:27]));
        end
    endtask : chk_out

    task automatic sweep;
        for (c = 0; c < 8; c++) begin
            rate2_active      <= c[0];
            deemphasis_select <= c[1];
            low_swing_enable  <= c[2];
            chk_out();
        end
    endtask : sweep

    task automatic do_reset(input int n);
        aresetn <= 1'b0;
        repeat (n) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (c = 0; c < 4; c++) begin
            exp_reg[c] = LANE_CTRL0_RESET;
        end
    endtask : do_reset

    initial begin
        aclk = 0;
        aresetn = 0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
        lane_select = '0;
        deemphasis_select = 1;
        low_swing_enable = 0;
        rate2_active = 1;
        eq_rate1_lanes = EQ1;
        err_count = 0;
        n_checks = 0;
        do_reset(20);
        rd_all();
        sweep();
        $display("Test reset values done");
        wr_lane(2, 32'hFFFF_FFFF, 4'hF);
        wr_lane(1, 32'h1234_5678, 4'hF);
        wr_lane(3, 32'hA5A5_A5A5, 4'hF);
        wr_lane(3, 32'h00FF_0000, 4'h4);
        rd_all();
        sweep();
        $display("Test lane writes done");
        wr_lane(1, 32'h1634_5678, 4'hF);
        wr_lane(0, 32'h0400_0000, 4'hF);
        sweep();
        $display("Test slew disable done");
        lane_select <= 4'h0;
        axi_write(12'h004, 32'hFFFF_FFFF, 4'hF, rsp);
        check(32'(rsp), 32'(RESP_SLVERR));
        axi_read(12'h004, rd, rsp);
        check(rd, 32'h0);
        check(32'(rsp), 32'(RESP_SLVERR));
        wr_lane(5, 32'h0000_0000, 4'hF);
        axi_read(LANE_CTRL0_OFFSET, rd, rsp);
        check(rd, 32'h0);
        check(32'(rsp), 32'(RESP_OKAY));
        rd_all();
        $display("Test refused accesses done");
        do_reset(3);
        rd_all();
        chk_out();
        $display("Test mid-run reset done");
        give_verdict();
    end

endmodule : tb

`default_nettype wire

//--- verilog/stl_lane_store.sv
// Per-lane sticky storage of the transmitter lane settings.
// Assumes writes arrive already merged with byte strobes, one lane at a time.
`timescale 1ns/1ps
`default_nettype none

module stl_lane_store #(
    parameter int NUM_LANES = 4
) (
    // Clock and fundamental reset
    input  wire logic                              aclk,
    input  wire logic                              aresetn,
    // Write port
    input  wire logic                              wr_en,
    input  wire logic [3:0]                        wr_lane,
    input  wire logic [stl_pkg::LANE_W-1:0]        wr_value,
    // All lanes
    output logic [NUM_LANES*stl_pkg::LANE_W-1:0]   lanes_flat
);
    import stl_pkg::*;

    // Lane index is four bits wide
    if (NUM_LANES < 1 || NUM_LANES > 16) begin : g_bad_lanes
        $error("NUM_LANES must lie in 1..16");
    end

    logic [LANE_W-1:0] store_ff [NUM_LANES];

    generate
        for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
            logic [LANE_W-1:0] nxt_store;

            always_comb begin
                nxt_store = store_ff[i];
                if (wr_en && (wr_lane == 4'(i))) begin
                    nxt_store = wr_value;
                end
            end

            // Only the fundamental reset returns the store to LANE_RESET
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    store_ff[i] <= LANE_RESET;
                end else begin
                    store_ff[i] <= nxt_store;
                end
            end

            assign lanes_flat[i*LANE_W +: LANE_W] = store_ff[i];

            a_reset_default: assert property (
                @(posedge aclk) !aresetn |=> store_ff[i] == LANE_RESET)
                else $error("lane store not at default after reset");
        end
    endgenerate

endmodule : stl_lane_store

`default_nettype wire

//--- verilog/stl_tx_lane_settings.sv
// Transmitter lane settings bank (register bits 31:10) with AXI4-Lite slave
// and per-lane drive of the equalization, slew and boost settings.
// Assumes lane select, de-emphasis select, low-swing enable and the rate
// come from the neighbouring transceiver control logic, synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - In rate two full swing with the -3.5 dB choice, bits 11:10 (reset 1) set equalization.
// - In rate two full swing with the -6.0 dB choice, bits 13:12 (reset 1) set equalization.
// - With low swing enabled, bits 15:14 (reset 0) set equalization at both rates.
// - Bits 17:16 (reset 2) pick the rate one coarse edge rate: 48, 50, 60 or 89 ps.
// - Bits 20:18 (reset 0) give the rate one fine slew adjustment.
// - Bits 22:21 (reset 0) pick the rate two coarse edge rate with the same coding.
// - Bits 25:23 (reset 0) give the rate two fine slew adjustment.
// - Bit 26 set overrides all slew fields and drives the fastest slew.
// - Bits 28:27 (reset 1) set amplitude boost from none (0) to most (3).
// - A write lands only on the lane picked by the lane select field.
// - Every lane keeps its own programmed settings, selected or not.
// - Bits 31:29 are read-only and read as zero.
module stl_tx_lane_settings #(
    parameter int NUM_LANES = 4
) (
    // Clock and fundamental reset
    input  wire logic                           aclk,
    input  wire logic                           aresetn,
    // AXI4-Lite write address
    input  wire logic                           awvalid,
    output logic                                awready,
    input  wire logic [stl_pkg::ADDR_W-1:0]     awaddr,
    input  wire logic [2:0]                     awprot,
    // AXI4-Lite write data
    input  wire logic                           wvalid,
    output logic                                wready,
    input  wire logic [31:0]                    wdata,
    input  wire logic [3:0]                     wstrb,
    // AXI4-Lite write response
    output logic                                bvalid,
    input  wire logic                           bready,
    output logic [1:0]                          bresp,
    // AXI4-Lite read address
    input  wire logic                           arvalid,
    output logic                                arready,
    input  wire logic [stl_pkg::ADDR_W-1:0]     araddr,
    input  wire logic [2:0]                     arprot,
    // AXI4-Lite read data
    output logic                                rvalid,
    input  wire logic                           rready,
    output logic [31:0]                         rdata,
    output logic [1:0]                          rresp,
    // Transceiver control context
    input  wire logic [3:0]                     lane_select,
    input  wire logic                           deemphasis_select,
    input  wire logic                           low_swing_enable,
    input  wire logic                           rate2_active,
    input  wire logic [2*NUM_LANES-1:0]         eq_rate1_lanes,
    // Per-lane driver settings
    output logic [2*NUM_LANES-1:0]              tx_eq_ff,
    output logic [2*NUM_LANES-1:0]              tx_coarse_slew_ff,
    output logic [3*NUM_LANES-1:0]              tx_fine_slew_ff,
    output logic [2*NUM_LANES-1:0]              tx_amp_boost_ff
);
    import stl_pkg::*;

    // Lane index is four bits wide
    if (NUM_LANES < 1 || NUM_LANES > 16) begin : g_bad_lanes
        $error("NUM_LANES must lie in 1..16");
    end

    // Bus state
    logic                awready_ff, nxt_awready;
    logic                wready_ff, nxt_wready;
    logic                aw_have_ff, nxt_aw_have;
    logic                w_have_ff, nxt_w_have;
    logic [ADDR_W-1:0]   waddr_ff, nxt_waddr;
    logic [31:0]         wdata_ff, nxt_wdata;
    logic [3:0]          wstrb_ff, nxt_wstrb;
    logic                bvalid_ff, nxt_bvalid;
    logic [1:0]          bresp_ff, nxt_bresp;
    stl_rd_e             rd_state_ff, nxt_rd_state;
    logic                arready_ff, nxt_arready;
    logic [31:0]         rdata_ff, nxt_rdata;
    logic [1:0]          rresp_ff, nxt_rresp;

    // Store access
    logic                          wr_en;
    logic [3:0]                    wr_lane;
    logic [LANE_W-1:0]             wr_value;
    logic [NUM_LANES*LANE_W-1:0]   lanes_flat;
    logic [LANE_W-1:0]             wr_old;
    logic [LANE_W-1:0]             rd_lane_val;
    logic [31:0]                   old_word;
    logic [31:0]                   new_word;
    logic                          w_mapped;
    logic                          r_mapped;
    logic                          sel_valid;

    // Five bits so that sixteen lanes still compare correctly
    assign sel_valid = {1'b0, lane_select} < 5'(NUM_LANES);
    assign w_mapped  = waddr_ff[ADDR_W-1:2] == LANE_CTRL0_OFFSET[ADDR_W-1:2];
    assign r_mapped  = araddr[ADDR_W-1:2] == LANE_CTRL0_OFFSET[ADDR_W-1:2];

    always_comb begin
        wr_old      = '0;
        rd_lane_val = '0;
        for (int i = 0; i < NUM_LANES; i++) begin
            if (lane_select == 4'(i)) begin
                wr_old      = lanes_flat[i*LANE_W +: LANE_W];
                rd_lane_val = lanes_flat[i*LANE_W +: LANE_W];
            end
        end
    end

    // Byte strobes merge the write into the selected lane's word
    always_comb begin
        old_word = {3'h0, wr_old, 10'h000};
        new_word = old_word;
        for (int b = 0; b < 4; b++) begin
            if (wstrb_ff[b]) begin
                new_word[b*8 +: 8] = wdata_ff[b*8 +: 8];
            end
        end
        wr_value = new_word[STORE_BASE +: LANE_W];
    end

    assign wr_lane = lane_select;

    // Write channel: address and data taken in either order
    always_comb begin
        nxt_aw_have = aw_have_ff;
        nxt_w_have  = w_have_ff;
        nxt_waddr   = waddr_ff;
        nxt_wdata   = wdata_ff;
        nxt_wstrb   = wstrb_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        wr_en       = 1'b0;
        if (awvalid && awready_ff) begin
            nxt_aw_have = 1'b1;
            nxt_waddr   = awaddr;
        end
        if (wvalid && wready_ff) begin
            nxt_w_have = 1'b1;
            nxt_wdata  = wdata;
            nxt_wstrb  = wstrb;
        end
        if (bvalid_ff && bready) begin
            nxt_bvalid = 1'b0;
        end
        if (aw_have_ff && w_have_ff && !bvalid_ff) begin
            wr_en       = w_mapped && sel_valid;
            nxt_aw_have = 1'b0;
            nxt_w_have  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = w_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        nxt_awready = !nxt_aw_have && !nxt_bvalid;
        nxt_wready  = !nxt_w_have && !nxt_bvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            aw_have_ff <= 1'b0;
            w_have_ff  <= 1'b0;
            waddr_ff   <= '0;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
        end else begin
            awready_ff <= nxt_awready;
            wready_ff  <= nxt_wready;
            aw_have_ff <= nxt_aw_have;
            w_have_ff  <= nxt_w_have;
            waddr_ff   <= nxt_waddr;
            wdata_ff   <= nxt_wdata;
            wstrb_ff   <= nxt_wstrb;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
        end
    end

    // Read channel
    always_comb begin
        nxt_rd_state = rd_state_ff;
        nxt_rdata    = rdata_ff;
        nxt_rresp    = rresp_ff;
        unique case (rd_state_ff)
            RD_IDLE: begin
                if (arvalid && arready_ff) begin
                    nxt_rd_state = RD_RESP;
                    nxt_rresp    = r_mapped ? RESP_OKAY : RESP_SLVERR;
                    nxt_rdata    = 32'h0000_0000;
                    if (r_mapped && sel_valid) begin
                        // Reserved bits above stay zero
                        nxt_rdata = {3'h0, rd_lane_val, 10'h000};
                    end
                end
            end
            RD_RESP: begin
                if (rready) begin
                    nxt_rd_state = RD_IDLE;
                end
            end
            default: begin
                nxt_rd_state = RD_IDLE;
            end
        endcase
        nxt_arready = nxt_rd_state == RD_IDLE;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_ff <= RD_IDLE;
            arready_ff  <= 1'b0;
            rdata_ff    <= 32'h0000_0000;
            rresp_ff    <= RESP_OKAY;
        end else begin
            rd_state_ff <= nxt_rd_state;
            arready_ff  <= nxt_arready;
            rdata_ff    <= nxt_rdata;
            rresp_ff    <= nxt_rresp;
        end
    end

    assign awready = awready_ff;
    assign wready  = wready_ff;
    assign bvalid  = bvalid_ff;
    assign bresp   = bresp_ff;
    assign arready = arready_ff;
    assign rvalid  = rd_state_ff == RD_RESP;
    assign rdata   = rdata_ff;
    assign rresp   = rresp_ff;

    stl_lane_store #(
        .NUM_LANES (NUM_LANES)
    ) u_store (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .wr_en      (wr_en),
        .wr_lane    (wr_lane),
        .wr_value   (wr_value),
        .lanes_flat (lanes_flat)
    );

    // Per-lane drive of the analog settings
    generate
        for (genvar i = 0; i < NUM_LANES; i++) begin : g_drive
            logic [LANE_W-1:0] lv;
            logic [1:0]        nxt_eq;
            logic [1:0]        nxt_coarse;
            logic [2:0]        nxt_fine;
            logic [1:0]        nxt_boost;

            assign lv = lanes_flat[i*LANE_W +: LANE_W];

            always_comb begin
                if (low_swing_enable) begin
                    nxt_eq = lv[S_EQ_LS +: 2];
                end else if (!rate2_active) begin
                    nxt_eq = eq_rate1_lanes[2*i +: 2];
                end else if (deemphasis_select) begin
                    nxt_eq = lv[S_EQ_LO +: 2];
                end else begin
                    nxt_eq = lv[S_EQ_HI +: 2];
                end
                if (lv[S_SLEW_DIS]) begin
                    nxt_coarse = COARSE_FASTEST;
                    nxt_fine   = FINE_FASTEST;
                end else if (rate2_active) begin
                    nxt_coarse = lv[S_CS2 +: 2];
                    nxt_fine   = lv[S_FS2 +: 3];
                end else begin
                    nxt_coarse = lv[S_CS1 +: 2];
                    nxt_fine   = lv[S_FS1 +: 3];
                end
                nxt_boost = lv[S_BOOST +: 2];
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    tx_eq_ff[2*i +: 2]          <= LANE_RESET[S_EQ_LO +: 2];
                    tx_coarse_slew_ff[2*i +: 2] <= LANE_RESET[S_CS1 +: 2];
                    tx_fine_slew_ff[3*i +: 3]   <= LANE_RESET[S_FS1 +: 3];
                    tx_amp_boost_ff[2*i +: 2]   <= LANE_RESET[S_BOOST +: 2];
                end else begin
                    tx_eq_ff[2*i +: 2]          <= nxt_eq;
                    tx_coarse_slew_ff[2*i +: 2] <= nxt_coarse;
                    tx_fine_slew_ff[3*i +: 3]   <= nxt_fine;
                    tx_amp_boost_ff[2*i +: 2]   <= nxt_boost;
                end
            end
        end
    endgenerate

    // Checks on lane 0, on the reserved read bits and on the write answer
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [LANE_W-1:0] l0;
    assign l0 = lanes_flat[LANE_W-1:0];

    sequence s_write_done;
        aw_have_ff && w_have_ff && !bvalid_ff;
    endsequence

    sequence s_other_lane_write;
        s_write_done ##0 (lane_select != 4'h0);
    endsequence

    // Drive flops sit at reset values on the release edge: skip that edge
    a_eq_low_dee: assert property (
        aresetn && !low_swing_enable && rate2_active && deemphasis_select
        |=> tx_eq_ff[1:0] == $past(l0[S_EQ_LO +: 2]))
        else $error("eq not from -3.5 dB rate two field");

    a_eq_high_dee: assert property (
        aresetn && !low_swing_enable && rate2_active && !deemphasis_select
        |=> tx_eq_ff[1:0] == $past(l0[S_EQ_HI +: 2]))
        else $error("eq not from -6.0 dB rate two field");

    a_eq_low_swing: assert property (
        aresetn && low_swing_enable
        |=> tx_eq_ff[1:0] == $past(l0[S_EQ_LS +: 2]))
        else $error("eq not from low swing field");

    a_slew_rate1: assert property (
        aresetn && !l0[S_SLEW_DIS] && !rate2_active
        |=> tx_coarse_slew_ff[1:0] == $past(l0[S_CS1 +: 2])
            && tx_fine_slew_ff[2:0] == $past(l0[S_FS1 +: 3]))
        else $error("rate one slew mismatch");

    a_slew_rate2: assert property (
        aresetn && !l0[S_SLEW_DIS] && rate2_active
        |=> tx_coarse_slew_ff[1:0] == $past(l0[S_CS2 +: 2])
            && tx_fine_slew_ff[2:0] == $past(l0[S_FS2 +: 3]))
        else $error("rate two slew mismatch");

    a_slew_disable: assert property (
        l0[S_SLEW_DIS] |=> tx_coarse_slew_ff[1:0] == COARSE_FASTEST
            && tx_fine_slew_ff[2:0] == FINE_FASTEST)
        else $error("slew disable did not force fastest");

    a_amp_boost: assert property (
        ##1 tx_amp_boost_ff[1:0] == $past(l0[S_BOOST +: 2]))
        else $error("boost output mismatch");

    a_lane_isolate: assert property (
        s_other_lane_write |=> $stable(l0))
        else $error("write reached an unselected lane");

    a_sticky_idle: assert property (
        !(aw_have_ff && w_have_ff) |=> $stable(l0))
        else $error("lane store changed without a write");

    a_rsv_zero: assert property (
        rvalid |-> rdata[31:POS_RSV_LO] == 3'h0 && rdata[9:0] == 10'h000)
        else $error("reserved read bits not zero");

    a_write_resp: assert property (
        s_write_done |=> bvalid
            && bresp == ($past(w_mapped) ? RESP_OKAY : RESP_SLVERR))
        else $error("write answer late or wrong");

endmodule : stl_tx_lane_settings

`default_nettype wire
